// ---- tuning_pkg.sv ----
// What this block does
// - Override bit 13 set makes bits 12:8 the channel D swing.
// - Override bit 5 set makes bits 4:0 the channel C swing.
// - Reset clears overrides, swing fields to 10000 and applied swings to 00000; bits 15:14, 7:6 read 00.
// - Select bit 4 at 1 sends the test clock out, at 0 the normal clock.
// - Clock register bits 15:5 and 3:0 ignore writes and read zero.
package tuning_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int REG_COUNT = 8;
    localparam int ADDR_W = 11;
    localparam int INDEX_W = 9;
    localparam int WORD_W = 16;
    localparam int SWING_W = 5;
    localparam int CHANNELS = 2;

    // Register indexes; the byte address is four times the index.
    localparam logic [INDEX_W-1:0] IDX_SWING_CD = 9'h0A3;
    localparam logic [INDEX_W-1:0] IDX_LOWPASS = 9'h0B3;
    localparam logic [INDEX_W-1:0] IDX_EQ_ENABLE = 9'h0C0;
    localparam logic [INDEX_W-1:0] IDX_CLOCK_SEL = 9'h0C6;
    localparam logic [INDEX_W-1:0] IDX_SYNC_BUF = 9'h0E9;
    localparam logic [INDEX_W-1:0] IDX_LOOPBACK = 9'h0FE;
    localparam logic [INDEX_W-1:0] IDX_SIG_PROC = 9'h100;
    localparam logic [INDEX_W-1:0] IDX_FFE = 9'h12C;

    // Slot numbers of the registers in the storage array.
    localparam int SLOT_SWING_CD = 0;
    localparam int SLOT_LOWPASS = 1;
    localparam int SLOT_EQ_ENABLE = 2;
    localparam int SLOT_CLOCK_SEL = 3;
    localparam int SLOT_SYNC_BUF = 4;
    localparam int SLOT_LOOPBACK = 5;
    localparam int SLOT_SIG_PROC = 6;
    localparam int SLOT_FFE = 7;

    localparam logic [INDEX_W-1:0] SLOT_INDEX [REG_COUNT] = '{
        IDX_SWING_CD, IDX_LOWPASS, IDX_EQ_ENABLE, IDX_CLOCK_SEL,
        IDX_SYNC_BUF, IDX_LOOPBACK, IDX_SIG_PROC, IDX_FFE};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SWING_D_OVR_BIT = 13;
    localparam int SWING_D_LSB = 8;
    localparam int SWING_C_OVR_BIT = 5;
    localparam int SWING_C_LSB = 0;
    localparam int CLOCK_SEL_BIT = 4;
    localparam int FFE_W = 10;

    // ----------------------------------------------------------------
    // Writable masks and reset values
    // ----------------------------------------------------------------
    localparam logic [WORD_W-1:0] MASK_SWING_CD = 16'h3F3F;
    localparam logic [WORD_W-1:0] MASK_CLOCK_SEL = 16'h0010;
    localparam logic [WORD_W-1:0] MASK_FFE = 16'h03FF;
    localparam logic [WORD_W-1:0] MASK_FULL = 16'hFFFF;

    localparam logic [WORD_W-1:0] RST_SWING_CD = 16'h1010;
    localparam logic [WORD_W-1:0] RST_LOWPASS = 16'h0000;
    localparam logic [WORD_W-1:0] RST_EQ_ENABLE = 16'h0000;
    localparam logic [WORD_W-1:0] RST_CLOCK_SEL = 16'h0000;
    localparam logic [WORD_W-1:0] RST_SYNC_BUF = 16'h9F22;
    localparam logic [WORD_W-1:0] RST_LOOPBACK = 16'h0001;
    localparam logic [WORD_W-1:0] RST_SIG_PROC = 16'h0000;
    localparam logic [WORD_W-1:0] RST_FFE = 16'h0C00;

    localparam logic [WORD_W-1:0] SLOT_MASK [REG_COUNT] = '{
        MASK_SWING_CD, MASK_FULL, MASK_FULL, MASK_CLOCK_SEL,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FFE};

    localparam logic [WORD_W-1:0] SLOT_RESET [REG_COUNT] = '{
        RST_SWING_CD, RST_LOWPASS, RST_EQ_ENABLE, RST_CLOCK_SEL,
        RST_SYNC_BUF, RST_LOOPBACK, RST_SIG_PROC, RST_FFE};

endpackage

// ---- tuning_link_if.sv ----
`timescale 1ns/1ps
// Carries decode and swing signals between the bank and its helpers.
interface tuning_link_if;
    import tuning_pkg::*;

    logic [ADDR_W-1:0] addr;
    logic [REG_COUNT-1:0] sel;
    logic hit;
    logic [CHANNELS-1:0] ovr;
    logic [CHANNELS-1:0][SWING_W-1:0] val;
    logic [CHANNELS-1:0][SWING_W-1:0] nominal;
    logic [CHANNELS-1:0][SWING_W-1:0] swing;

    modport decode (input addr, output sel, output hit);
    modport swing_side (input ovr, input val, input nominal, output swing);
    modport core (output addr, input sel, input hit, output ovr,
        output val, output nominal, input swing);
endinterface

// ---- tuning_decoder.sv ----
`timescale 1ns/1ps
// Turns a byte address into a one-hot register select.
module tuning_decoder (
    tuning_link_if.decode link
);
    import tuning_pkg::*;

    // ----------------------------------------------------------------
    // Address compare
    // ----------------------------------------------------------------
    wire aligned;

    // Only word-aligned addresses can hit a register.
    assign aligned = (link.addr[1:0] == 2'h0);

    // One comparator per register slot.
    genvar i;
    generate
        for (i = 0; i < REG_COUNT; i++) begin : g_cmp
            assign link.sel[i] = aligned
                && (link.addr[ADDR_W-1:2] == SLOT_INDEX[i]);
        end
    endgenerate

    // Any slot matched.
    assign link.hit = |link.sel;
endmodule

// ---- swing_apply.sv ----
`timescale 1ns/1ps
// Picks the applied line driver swing for each channel.
module swing_apply (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    tuning_link_if.swing_side link
);
    import tuning_pkg::*;

    // ----------------------------------------------------------------
    // Per-channel swing selection
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic [SWING_W-1:0] swing_q;
            wire [SWING_W-1:0] next_swing;

            // The override value wins over the trimmed nominal swing.
            assign next_swing = link.ovr[ch] ? link.val[ch]
                : link.nominal[ch];

            // Registered so the analog side sees a clean word.
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    swing_q <= '0;
                end else if (ce_i) begin
                    swing_q <= next_swing;
                end
            end

            assign link.swing[ch] = swing_q;
        end
    endgenerate
endmodule

// ---- phy_tuning_register_bank.sv ----
`timescale 1ns/1ps
// Bank of 16-bit tuning and test registers on an Avalon-MM slave.
module phy_tuning_register_bank (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [tuning_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [tuning_pkg::SWING_W-1:0] nominal_swing_c_i,
    input wire logic [tuning_pkg::SWING_W-1:0] nominal_swing_d_i,
    input wire logic transmit_test_clock_i,
    input wire logic normal_clock_i,
    output logic [tuning_pkg::SWING_W-1:0] driver_swing_c_o,
    output logic [tuning_pkg::SWING_W-1:0] driver_swing_d_o,
    output logic clock_out_o,
    output logic [tuning_pkg::WORD_W-1:0] receiver_lowpass_word_o,
    output logic [tuning_pkg::WORD_W-1:0] receiver_equalizer_enable_word_o,
    output logic [tuning_pkg::WORD_W-1:0] sync_buffer_word_o,
    output logic [tuning_pkg::WORD_W-1:0] loopback_setup_value_o,
    output logic [tuning_pkg::WORD_W-1:0] signal_processor_word_o,
    output logic [tuning_pkg::FFE_W-1:0] feedforward_equalizer_field_o
);
    import tuning_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    tuning_link_if link ();

    tuning_decoder u_decoder (
        .link (link.decode)
    );

    swing_apply u_swing (
        .clk_i (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i (ce_i),
        .link (link.swing_side)
    );

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    logic ack_q;
    wire request;
    wire accept;
    wire do_write;
    wire capture_read;

    // A request waits one cycle, then completes while the enable is high.
    assign request = avs_read_i | avs_write_i;
    assign accept = request & ack_q & ce_i;
    assign do_write = avs_write_i & accept;
    assign capture_read = avs_read_i & ~ack_q & ce_i;
    assign avs_waitrequest_o = request & ~accept;
    assign link.addr = avs_address_i;

    // The acknowledge toggles on for exactly one enabled cycle.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= request & ~ack_q;
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] reg_q [REG_COUNT];
    wire [WORD_W-1:0] lane_mask;
    wire [WORD_W-1:0] read_chain [REG_COUNT+1];

    // Byte enables of the low two lanes gate the 16-bit word.
    assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign read_chain[0] = '0;

    genvar i;
    generate
        for (i = 0; i < REG_COUNT; i++) begin : g_reg
            wire [WORD_W-1:0] wmask;
            wire [WORD_W-1:0] next_reg;

            // Read-only bits never take write data.
            assign wmask = SLOT_MASK[i] & lane_mask;
            assign next_reg = (reg_q[i] & ~wmask)
                | (avs_writedata_i[WORD_W-1:0] & wmask);

            // Reset loads the documented value into every bit.
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    reg_q[i] <= SLOT_RESET[i];
                end else if (ce_i && do_write && link.sel[i]) begin
                    reg_q[i] <= next_reg;
                end
            end

            // Read-back OR chain; unselected slots add zero.
            assign read_chain[i+1] = read_chain[i]
                | (link.sel[i] ? reg_q[i] : '0);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Captured in the waiting cycle so it stands at the completing edge.
    // Unmapped addresses read as zero; the upper lanes always read zero.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= '0;
        end else if (capture_read) begin
            avs_readdata_o <= {16'h0000, read_chain[REG_COUNT]};
        end
    end

    // ----------------------------------------------------------------
    // Swing override fields
    // ----------------------------------------------------------------
    // Channel C is slot 0 of the helper, channel D slot 1.
    assign link.ovr[0] = reg_q[SLOT_SWING_CD][SWING_C_OVR_BIT];
    assign link.val[0] =
        reg_q[SLOT_SWING_CD][SWING_C_LSB +: SWING_W];
    assign link.ovr[1] = reg_q[SLOT_SWING_CD][SWING_D_OVR_BIT];
    assign link.val[1] =
        reg_q[SLOT_SWING_CD][SWING_D_LSB +: SWING_W];
    assign link.nominal[0] = nominal_swing_c_i;
    assign link.nominal[1] = nominal_swing_d_i;
    assign driver_swing_c_o = link.swing[0];
    assign driver_swing_d_o = link.swing[1];

    // ----------------------------------------------------------------
    // Clock output multiplexer
    // ----------------------------------------------------------------
    // The test clock replaces the normal clock during compliance tests.
    // The select is a register, so it only moves on a software write or a reset.
    assign clock_out_o = reg_q[SLOT_CLOCK_SEL][CLOCK_SEL_BIT]
        ? transmit_test_clock_i : normal_clock_i;

    // ----------------------------------------------------------------
    // Configuration words to the analog and signal processing side
    // ----------------------------------------------------------------
    // The loopback word takes effect in the core only after a soft
    // reset issued by software through the main control register.
    assign loopback_setup_value_o = reg_q[SLOT_LOOPBACK];
    assign receiver_lowpass_word_o = reg_q[SLOT_LOWPASS];
    assign receiver_equalizer_enable_word_o = reg_q[SLOT_EQ_ENABLE];
    assign sync_buffer_word_o = reg_q[SLOT_SYNC_BUF];
    assign signal_processor_word_o = reg_q[SLOT_SIG_PROC];
    assign feedforward_equalizer_field_o = reg_q[SLOT_FFE][FFE_W-1:0];
endmodule

// ---- tuning_asserts.sv ----
`timescale 1ns/1ps
// Watches the bank's bus handshake, reserved bits and applied outputs.
module tuning_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [tuning_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [tuning_pkg::SWING_W-1:0] nominal_swing_c_i,
    input wire logic transmit_test_clock_i,
    input wire logic normal_clock_i,
    input wire logic [tuning_pkg::SWING_W-1:0] driver_swing_c_o,
    input wire logic clock_out_o
);
    import tuning_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // Shadow of the channel C field and the clock select bit
    // ------------------------------------------------------------
    logic [5:0] swing_c_copy;
    logic clk_sel_copy;
    wire done = ce_i && !avs_waitrequest_o && (avs_read_i || avs_write_i);
    wire wr_lo = done && avs_write_i && avs_byteenable_i[0];
    wire at_swing = avs_address_i == {IDX_SWING_CD, 2'b00};
    wire at_clk = avs_address_i == {IDX_CLOCK_SEL, 2'b00};
    // The shadow follows only completed low-byte writes.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            swing_c_copy <= 6'h10;
            clk_sel_copy <= 1'b0;
        end else if (wr_lo && at_swing) begin
            swing_c_copy <= avs_writedata_i[5:0];
        end else if (wr_lo && at_clk) begin
            clk_sel_copy <= avs_writedata_i[CLOCK_SEL_BIT];
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    clock_output_select_bit_route_a: assert property (
        clock_out_o == (clk_sel_copy ? transmit_test_clock_i
            : normal_clock_i))
        else $error("clock output does not follow select bit");
    swing_override_a: assert property (
        $past(rst_n_i) && $past(ce_i) && $past(swing_c_copy[5]) |->
        driver_swing_c_o == $past(swing_c_copy[4:0]))
        else $error("channel C swing ignores override");
    swing_nominal_a: assert property (
        $past(rst_n_i) && $past(ce_i) && !$past(swing_c_copy[5]) |->
        driver_swing_c_o == $past(nominal_swing_c_i))
        else $error("channel C swing not nominal");
    swing_reserved_a: assert property (
        done && avs_read_i && at_swing |->
        avs_readdata_o[15:14] == 2'b00 && avs_readdata_o[7:6] == 2'b00)
        else $error("swing reserved bits not zero");
    clk_reserved_a: assert property (
        done && avs_read_i && at_clk |->
        avs_readdata_o[15:5] == 11'h000 && avs_readdata_o[3:0] == 4'h0)
        else $error("clock select reserved bits not zero");
    clk_readback_a: assert property (
        done && avs_read_i && at_clk |-> avs_readdata_o[4] == clk_sel_copy)
        else $error("clock select bit readback wrong");
    upper_zero_a: assert property (
        done && avs_read_i |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    wait_answer_a: assert property (
        ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o ##1 ce_i
        |-> !avs_waitrequest_o)
        else $error("bus answer late");
    idle_low_a: assert property (
        !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest high while idle");
    cover property (wr_lo && at_clk && avs_writedata_i[CLOCK_SEL_BIT]);
    cover property (done && avs_read_i && at_swing);
    cover property (swing_c_copy[5] ##2 swing_c_copy[5]);
endmodule

bind phy_tuning_register_bank tuning_asserts u_chk (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .nominal_swing_c_i(nominal_swing_c_i),
    .transmit_test_clock_i(transmit_test_clock_i),
    .normal_clock_i(normal_clock_i), .driver_swing_c_o(driver_swing_c_o),
    .clock_out_o(clock_out_o));

// ---- tb_top.sv ----
`timescale 1ns/1ps
// Drives the bank over its bus and compares against hand-worked values.
module tb_top;
    import tuning_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0;
    logic tclk = 1'b0, nclk = 1'b0, wait_o, clk_o;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0, rdata, got;
    logic [3:0] be = 4'h0;
    logic ce = 1'b1;
    logic [SWING_W-1:0] nom_c = 5'h0A, nom_d = 5'h15, drv_c, drv_d;
    logic [WORD_W-1:0] lpf, eqe, syncw, loopw, dspw;
    logic [FFE_W-1:0] ffe;
    int fail_count = 0;
    int n_checks = 0;
    logic [15:0] rst_exp [8] = '{16'h1010, 16'h0000, 16'h0000, 16'h0000,
        16'h9F22, 16'h0001, 16'h0000, 16'h0C00};
    logic [15:0] rw_mask [8] = '{16'h3F3F, 16'hFFFF, 16'hFFFF, 16'h0010,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h03FF};
    logic [15:0] pat [2] = '{16'hFFFF, 16'h0000};

    phy_tuning_register_bank DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .nominal_swing_c_i(nom_c), .nominal_swing_d_i(nom_d),
        .transmit_test_clock_i(tclk), .normal_clock_i(nclk),
        .driver_swing_c_o(drv_c), .driver_swing_d_o(drv_d),
        .clock_out_o(clk_o), .receiver_lowpass_word_o(lpf),
        .receiver_equalizer_enable_word_o(eqe), .sync_buffer_word_o(syncw),
        .loopback_setup_value_o(loopw), .signal_processor_word_o(dspw),
        .feedforward_equalizer_field_o(ffe));

    // Clock and two unrelated-pattern sources for the output mux.
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        tclk <= ~tclk;
        nclk <= tclk ? ~nclk : nclk;
    end

    // One bus transfer; holds the request until waitrequest is seen low.
    task automatic xfer(input logic w, input logic [INDEX_W-1:0] idx,
        input logic [15:0] d, input logic [3:0] en);
        int n;
        n = 0;
        addr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        be <= en;
        wr <= w;
        rd <= !w;
        @(posedge clk_i);
        while (wait_o !== 1'b0 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        got = rdata;
        if (n >= 50) fail_count++;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] val);
        n_checks++;
        if (val !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, val);
        end
    endtask

    task automatic rdchk(input string what, input logic [INDEX_W-1:0] idx,
        input logic [15:0] exp);
        xfer(1'b0, idx, 16'h0000, 4'hF);
        check(what, {16'h0000, exp}, got);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Cuts a hang short far beyond the few hundred cycles the tests need.
    initial begin
        #(50 * 4000);
        fail_count++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < REG_COUNT; i++) begin
            rdchk("reset", SLOT_INDEX[i], rst_exp[i]);
        end
        $display("test reset values done");
        foreach (pat[p]) for (int i = 0; i < REG_COUNT; i++) begin
            xfer(1'b1, SLOT_INDEX[i], pat[p], 4'h3);
            rdchk("readback", SLOT_INDEX[i], (rst_exp[i] & ~rw_mask[i]) |
                (pat[p] & rw_mask[i]));
        end
        $display("test readback done");
        xfer(1'b1, IDX_LOWPASS, 16'h000C, 4'h3);
        xfer(1'b1, IDX_SIG_PROC, 16'h1027, 4'h3);
        xfer(1'b1, IDX_FFE, 16'h0E81, 4'h3);
        xfer(1'b1, IDX_LOOPBACK, 16'h7390, 4'h3);
        xfer(1'b1, IDX_SYNC_BUF, 16'h5AA5, 4'h3);
        xfer(1'b1, IDX_EQ_ENABLE, 16'hFFFF, 4'h3);
        xfer(1'b1, IDX_EQ_ENABLE, 16'h0000, 4'h3);
        rdchk("ffe", IDX_FFE, 16'h0E81);
        check("lowpass", 32'h000C, {16'h0000, lpf});
        check("dsp", 32'h1027, {16'h0000, dspw});
        check("ffe_field", 32'h0281, {22'h0, ffe});
        check("loopback", 32'h7390, {16'h0000, loopw});
        check("sync", 32'h5AA5, {16'h0000, syncw});
        check("eq", 32'h0000, {16'h0000, eqe});
        $display("test recommended values done");
        xfer(1'b1, IDX_SWING_CD, 16'hFFFF, 4'h1);
        rdchk("swing_lane", IDX_SWING_CD, 16'h003F);
        check("swing_c", 32'h1F, {27'h0, drv_c});
        check("swing_d", 32'h15, {27'h0, drv_d});
        xfer(1'b1, IDX_SWING_CD, 16'h3E05, 4'h3);
        @(posedge clk_i);
        check("swing_c", 32'h0A, {27'h0, drv_c});
        check("swing_d", 32'h1E, {27'h0, drv_d});
        $display("test swing done");
        // With the enable low a read must wait and the swing must freeze.
        nom_c <= 5'h07;
        ce <= 1'b0;
        fork
            rdchk("frozen_read", IDX_LOWPASS, 16'h000C);
            begin
                repeat (4) @(posedge clk_i);
                check("frozen_wait", 32'h1, {31'h0, wait_o});
                check("frozen_swing", 32'h0A, {27'h0, drv_c});
                ce <= 1'b1;
            end
        join
        check("thawed_swing", 32'h07, {27'h0, drv_c});
        $display("test clock enable done");
        xfer(1'b1, IDX_CLOCK_SEL, 16'hFFFF, 4'h3);
        rdchk("clock_sel", IDX_CLOCK_SEL, 16'h0010);
        repeat (3) begin
            @(negedge clk_i);
            check("test_clock", {31'h0, tclk}, {31'h0, clk_o});
        end
        @(posedge clk_i);
        xfer(1'b1, IDX_CLOCK_SEL, 16'h0000, 4'h3);
        repeat (3) begin
            @(negedge clk_i);
            check("normal_clock", {31'h0, nclk}, {31'h0, clk_o});
        end
        @(posedge clk_i);
        $display("test clock mux done");
        xfer(1'b1, 9'h0A4, 16'hFFFF, 4'h3);
        rdchk("unmapped", 9'h0A4, 16'h0000);
        xfer(1'b1, IDX_CLOCK_SEL, 16'h0010, 4'h3);
        // The loopback word changed earlier, so the test pulses rst_n_i to reset the device.
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdchk("rereset_swing", IDX_SWING_CD, 16'h1010);
        rdchk("rereset_clock", IDX_CLOCK_SEL, 16'h0000);
        $display("test unmapped and second reset done");
        print_verdict();
    end
endmodule
